// *** hdl/cpr_top.sv ***
`timescale 1ns/1ps
module cpr_top
	import cpr_pkg::*;
(
	input  wire logic        mclk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        por_reset_n_in,
	input  wire logic        hold_reset_n_in,
	input  wire logic        ctl_cs_n_in,
	input  wire logic        ctl_sclk_in,
	input  wire logic        ctl_sdi_in,
	output logic             ctl_sdo_out,
	output logic             ctl_sdo_oe_out,
	output logic             ctl_ready_out,
	input  wire logic [1:0]  rate_mode_in,
	input  wire logic        i2s_interface_select_in,
	input  wire logic        frame_clock_in,
	input  wire logic        soft_mute_pin_in,
	input  wire logic        adc1_data_in,
	input  wire logic        adc2_data_in,
	input  wire logic        serial_pass_in,
	output logic             serial_out_one_out,
	output logic             serial_out_two_out,
	output cpr_pkg::cpr_fmt_type dac3_format_out,
	output cpr_pkg::cpr_fmt_type dac2_format_out,
	output cpr_pkg::cpr_fmt_type dac1_format_out,
	output cpr_pkg::cpr_fmt_type passthru_input_format_out,
	output cpr_pkg::cpr_fmt_type passthru_output_format_out,
	output logic             passthru_frame_delay_out,
	output logic [11:0]      mclk_ratio_out,
	output logic             mclk_halve_out,
	output logic [3:0]       adc1_source_select_out,
	output logic [3:0]       adc2_source_select_out,
	output logic             adc1_reset_out,
	output logic             adc2_reset_out,
	output logic             dac_reset_out,
	output logic             soft_mute_out
);
	import cpr_pkg::*;

	cpr_word_if #(.WIDTH(WORD_W)) port_q ();
	cpr_word_if #(.WIDTH(WORD_W)) apply_q ();

	logic [2:0] rd_index;
	logic [7:0] rd_data;
	logic       ctl_busy;

	cpr_ctl_port u_port (
		.mclk_in        (mclk_in),
		.sys_rst_in     (sys_rst_in),
		.ctl_cs_n_in    (ctl_cs_n_in),
		.ctl_sclk_in    (ctl_sclk_in),
		.ctl_sdi_in     (ctl_sdi_in),
		.rd_data_in     (rd_data),
		.rd_index_out   (rd_index),
		.busy_out       (ctl_busy),
		.ctl_sdo_out    (ctl_sdo_out),
		.ctl_sdo_oe_out (ctl_sdo_oe_out),
		.wq             (port_q)
	);

	cpr_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.mclk_in    (mclk_in),
		.sys_rst_in (sys_rst_in),
		.wr         (port_q),
		.rd         (apply_q)
	);

	// Writes stall while a read answer is shifting out
	assign apply_q.ready = !ctl_busy;

	// Pin synchronisers
	logic [1:0] por_sync_reg, hold_sync_reg, mute_sync_reg, pass_sync_reg;
	logic [2:0] frame_sync_reg;

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			por_sync_reg   <= 2'h0;
			hold_sync_reg  <= 2'h0;
			mute_sync_reg  <= 2'h0;
			pass_sync_reg  <= 2'h0;
			frame_sync_reg <= 3'h0;
		end else begin
			por_sync_reg   <= {por_sync_reg[0], por_reset_n_in};
			hold_sync_reg  <= {hold_sync_reg[0], hold_reset_n_in};
			mute_sync_reg  <= {mute_sync_reg[0], soft_mute_pin_in};
			pass_sync_reg  <= {pass_sync_reg[0], serial_pass_in};
			frame_sync_reg <= {frame_sync_reg[1:0], frame_clock_in};
		end
	end

	logic por_active, sys_reset_state;
	assign por_active      = !por_sync_reg[1];
	assign sys_reset_state = por_sync_reg[1] && !hold_sync_reg[1];

	// Register file
	logic [7:0] fmt_reg, fmt_next;
	logic [7:0] pt_reg, pt_next;
	logic [7:0] adc1_reg, adc1_next;
	logic [7:0] adc2_reg, adc2_next;
	logic [7:0] dac_reg, dac_next;
	logic [7:0] wdata;
	logic [2:0] widx;

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] val,
			input logic [7:0] lock, input logic in_reset);
		logic [7:0] m;
		m = in_reset ? val : ((old & lock) | (val & ~lock));
		return {m[7:1], 1'b0};
	endfunction

	function automatic logic [7:0] merge_adc(input logic [7:0] old, input logic [7:0] val,
			input logic in_reset);
		logic [7:0] m;
		m = merge(old, val, LOCK_ADC, in_reset);
		m[PS_BIT] = m[PS_BIT] | (old[PS_BIT] & !in_reset);
		return m;
	endfunction

	always_comb begin
		wdata     = apply_q.data[7:0];
		widx      = apply_q.data[11:9];
		fmt_next  = fmt_reg;
		pt_next   = pt_reg;
		adc1_next = adc1_reg;
		adc2_next = adc2_reg;
		dac_next  = dac_reg;
		if (por_active) begin
			fmt_next  = REG_RESET;
			pt_next   = REG_RESET;
			adc1_next = REG_RESET;
			adc2_next = REG_RESET;
			dac_next  = REG_RESET;
		end else if (apply_q.valid && apply_q.ready) begin
			case (widx)
				reg_index(OFF_FMT):  fmt_next  = merge(fmt_reg, wdata, LOCK_FMT, sys_reset_state);
				reg_index(OFF_PT):   pt_next   = merge(pt_reg, wdata, LOCK_PT, sys_reset_state);
				reg_index(OFF_ADC1): adc1_next = merge_adc(adc1_reg, wdata, sys_reset_state);
				reg_index(OFF_ADC2): adc2_next = merge_adc(adc2_reg, wdata, sys_reset_state);
				reg_index(OFF_DAC):  dac_next  = merge(dac_reg, wdata, LOCK_DAC, sys_reset_state);
				default: ;
			endcase
		end
		case (rd_index)
			reg_index(OFF_FMT):  rd_data = fmt_reg;
			reg_index(OFF_PT):   rd_data = pt_reg;
			reg_index(OFF_ADC1): rd_data = adc1_reg;
			reg_index(OFF_ADC2): rd_data = adc2_reg;
			reg_index(OFF_DAC):  rd_data = dac_reg;
			default:             rd_data = 8'h00;
		endcase
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			fmt_reg  <= REG_RESET;
			pt_reg   <= REG_RESET;
			adc1_reg <= REG_RESET;
			adc2_reg <= REG_RESET;
			dac_reg  <= REG_RESET;
		end else begin
			fmt_reg  <= fmt_next;
			pt_reg   <= pt_next;
			adc1_reg <= adc1_next;
			adc2_reg <= adc2_next;
			dac_reg  <= dac_next;
		end
	end

	// Routing taken over only on the frame edge
	logic [5:0] route_reg, route_next;
	logic       frame_edge;

	always_comb begin
		frame_edge = i2s_interface_select_in
			? (!frame_sync_reg[1] && frame_sync_reg[2])
			: (frame_sync_reg[1] && !frame_sync_reg[2]);
		route_next = route_reg;
		if (frame_edge)
			route_next = {pt_reg[F2_BIT], pt_reg[F1_BIT], adc1_reg[SWA_BIT],
				adc1_reg[SWI_BIT], adc2_reg[SWA_BIT], adc2_reg[SWI_BIT]};
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			route_reg <= 6'h00;
		else
			route_reg <= route_next;
	end

	// Decoded outputs
	logic         a1, a2, o1_next, o2_next, ready_next;
	logic         pt_thru, mute_next, rst1_next, rst2_next;
	cpr_fmt_type  d3_next, d2_next, d1_next, pti_next, pto_next;
	logic [11:0]  ratio_next;
	logic [3:0]   s1_next, s2_next;

	always_comb begin
		a1 = adc1_data_in && !adc1_reg[PS_BIT];
		a2 = adc2_data_in && !adc2_reg[PS_BIT];
		o1_next = route_reg[2] ? pass_sync_reg[1] : (route_reg[3] ? a2 : a1);
		o2_next = route_reg[0] ? pass_sync_reg[1] : (route_reg[1] ? a1 : a2);
		o1_next = o1_next && !route_reg[4];
		o2_next = o2_next && !route_reg[5];
		d3_next = dac_fmt(fmt_reg[DAC3_LSB +: 2], i2s_interface_select_in);
		d2_next = dac_fmt(fmt_reg[DAC2_LSB +: 2], i2s_interface_select_in);
		d1_next = dac_fmt(fmt_reg[DAC1_LSB +: 2], i2s_interface_select_in);
		pt_thru = (pt_reg[PTI_LSB +: 2] == 2'b00) || (pt_reg[PTO_LSB +: 2] == 2'b00);
		pti_next = pt_thru ? FMT_THROUGH
			: pt_fmt(pt_reg[PTI_LSB +: 2], i2s_interface_select_in);
		pto_next = pt_thru ? FMT_THROUGH
			: pt_fmt(pt_reg[PTO_LSB +: 2], i2s_interface_select_in);
		ratio_next = mclk_ratio(rate_mode_in, fmt_reg[CKS_BIT], pt_reg[HALF_BIT]);
		s1_next    = source_num(adc1_reg[ASEL_LSB +: 3], SRC_PAIR1);
		s2_next    = source_num(adc2_reg[ASEL_LSB +: 3], SRC_PAIR2);
		rst1_next  = adc1_reg[PS_BIT] || sys_reset_state || por_active;
		rst2_next  = adc2_reg[PS_BIT] || sys_reset_state || por_active;
		mute_next  = dac_reg[MUTE_BIT] || mute_sync_reg[1];
		ready_next = port_q.ready;
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			serial_out_one_out         <= 1'b0;
			serial_out_two_out         <= 1'b0;
			dac3_format_out            <= FMT_MSB24;
			dac2_format_out            <= FMT_MSB24;
			dac1_format_out            <= FMT_MSB24;
			passthru_input_format_out  <= FMT_THROUGH;
			passthru_output_format_out <= FMT_THROUGH;
			passthru_frame_delay_out   <= 1'b0;
			mclk_ratio_out             <= RATIO_256;
			mclk_halve_out             <= 1'b0;
			adc1_source_select_out     <= SRC_PAIR1;
			adc2_source_select_out     <= SRC_PAIR2;
			adc1_reset_out             <= 1'b1;
			adc2_reset_out             <= 1'b1;
			dac_reset_out              <= 1'b1;
			soft_mute_out              <= 1'b0;
			ctl_ready_out              <= 1'b0;
		end else begin
			serial_out_one_out         <= o1_next;
			serial_out_two_out         <= o2_next;
			dac3_format_out            <= d3_next;
			dac2_format_out            <= d2_next;
			dac1_format_out            <= d1_next;
			passthru_input_format_out  <= pti_next;
			passthru_output_format_out <= pto_next;
			passthru_frame_delay_out   <= !pt_thru;
			mclk_ratio_out             <= ratio_next;
			mclk_halve_out             <= pt_reg[HALF_BIT];
			adc1_source_select_out     <= s1_next;
			adc2_source_select_out     <= s2_next;
			adc1_reset_out             <= rst1_next;
			adc2_reset_out             <= rst2_next;
			dac_reset_out              <= sys_reset_state || por_active;
			soft_mute_out              <= mute_next;
			ctl_ready_out              <= ready_next;
		end
	end
endmodule // cpr_top

// *** hdl/cpr_pkg.sv ***
package cpr_pkg;

	// Register offsets (command code high byte of write command)
	localparam logic [7:0] OFF_FMT  = 8'h22;
	localparam logic [7:0] OFF_PT   = 8'h24;
	localparam logic [7:0] OFF_ADC1 = 8'h26;
	localparam logic [7:0] OFF_ADC2 = 8'h28;
	localparam logic [7:0] OFF_DAC  = 8'h2a;
	localparam logic [7:0] REG_RESET = 8'h00;

	// Command code high nibbles
	localparam logic [3:0] CMD_WR = 4'h2;
	localparam logic [3:0] CMD_RD = 4'h3;

	// Field positions
	localparam int DAC3_LSB = 6;
	localparam int DAC2_LSB = 4;
	localparam int DAC1_LSB = 2;
	localparam int CKS_BIT  = 1;
	localparam int PTI_LSB  = 6;
	localparam int PTO_LSB  = 4;
	localparam int F2_BIT   = 3;
	localparam int F1_BIT   = 2;
	localparam int HALF_BIT = 1;
	localparam int ASEL_LSB = 5;
	localparam int SWA_BIT  = 4;
	localparam int SWI_BIT  = 3;
	localparam int PS_BIT   = 2;
	localparam int MUTE_BIT = 7;

	// Bits that only change while the system is held in reset
	localparam logic [7:0] LOCK_FMT = 8'hfe;
	localparam logic [7:0] LOCK_PT  = 8'hf2;
	localparam logic [7:0] LOCK_ADC = 8'h02;
	localparam logic [7:0] LOCK_DAC = 8'h70;

	// Master clock ratios in multiples of fs
	localparam logic [11:0] RATIO_256  = 12'h100;
	localparam logic [11:0] RATIO_384  = 12'h180;
	localparam logic [11:0] RATIO_1024 = 12'h400;
	localparam logic [11:0] RATIO_1536 = 12'h600;
	localparam logic [11:0] RATIO_NA   = 12'h000;

	// Control port framing
	localparam logic [4:0] BITS_CMD  = 5'h08;
	localparam logic [4:0] BITS_WORD = 5'h10;
	localparam int         WORD_W    = 16;
	localparam int         FIFO_DEPTH = 8;

	// Source numbers of the input selector
	localparam logic [3:0] SRC_PAIR1 = 4'h1;
	localparam logic [3:0] SRC_PAIR2 = 4'h2;
	localparam logic [3:0] SRC_BASE  = 4'h2;

	typedef enum logic [2:0] {
		FMT_MSB24   = 3'b000,
		FMT_LSB24   = 3'b001,
		FMT_LSB16   = 3'b010,
		FMT_I2S     = 3'b011,
		FMT_THROUGH = 3'b100,
		FMT_NA      = 3'b111
	} cpr_fmt_type;

	function automatic logic [2:0] reg_index(input logic [7:0] off);
		return off[3:1];
	endfunction

	function automatic cpr_fmt_type dac_fmt(input logic [1:0] code, input logic i2s);
		if (i2s)
			return FMT_I2S;
		case (code)
			2'b00:   return FMT_MSB24;
			2'b01:   return FMT_LSB24;
			2'b11:   return FMT_LSB16;
			default: return FMT_NA;
		endcase
	endfunction

	function automatic cpr_fmt_type pt_fmt(input logic [1:0] code, input logic i2s);
		case (code)
			2'b00:   return FMT_THROUGH;
			2'b01:   return i2s ? FMT_I2S : FMT_MSB24;
			2'b10:   return i2s ? FMT_NA : FMT_LSB24;
			2'b11:   return i2s ? FMT_NA : FMT_LSB16;
			default: return FMT_NA;
		endcase
	endfunction

	function automatic logic [11:0] mclk_ratio(input logic [1:0] mode, input logic mclk_ratio_select,
			input logic halve);
		logic [11:0] r;
		case (mode)
			2'b00:   r = mclk_ratio_select ? RATIO_384 : RATIO_256;
			2'b01:   r = mclk_ratio_select ? RATIO_1536 : RATIO_1024;
			2'b10:   r = (mclk_ratio_select || halve) ? RATIO_NA : RATIO_256;
			default: r = RATIO_NA;
		endcase
		return halve ? {r[10:0], 1'b0} : r;
	endfunction

	function automatic logic [3:0] source_num(input logic [2:0] code, input logic [3:0] pair);
		return (code == 3'b000) ? pair : SRC_BASE + {1'b0, code};
	endfunction

endpackage

// *** hdl/cpr_word_if.sv ***
`timescale 1ns/1ps
interface cpr_word_if #(parameter int WIDTH = 16);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// *** hdl/cpr_fifo.sv ***
`timescale 1ns/1ps
module cpr_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic mclk_in,
	input  wire logic sys_rst_in,
	cpr_word_if.snk   wr,
	cpr_word_if.src   rd
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg, wr_ptr_next;
	logic [AW-1:0]    rd_ptr_reg, rd_ptr_next;
	logic [AW:0]      count_reg, count_next;
	logic             push, pop;

	assign wr.ready = (count_reg != (AW+1)'(DEPTH));
	assign rd.valid = (count_reg != '0);
	assign rd.data  = mem[rd_ptr_reg];

	always_comb begin
		push        = wr.valid && wr.ready;
		pop         = rd.valid && rd.ready;
		wr_ptr_next = push ? AW'((wr_ptr_reg + 1'b1) % DEPTH) : wr_ptr_reg;
		rd_ptr_next = pop ? AW'((rd_ptr_reg + 1'b1) % DEPTH) : rd_ptr_reg;
		count_next  = count_reg + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg  <= count_next;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (push)
			mem[wr_ptr_reg] <= wr.data;
	end
endmodule // cpr_fifo

// *** hdl/cpr_ctl_port.sv ***
`timescale 1ns/1ps
module cpr_ctl_port
	import cpr_pkg::*;
(
	input  wire logic       mclk_in,
	input  wire logic       sys_rst_in,
	input  wire logic       ctl_cs_n_in,
	input  wire logic       ctl_sclk_in,
	input  wire logic       ctl_sdi_in,
	input  wire logic [7:0] rd_data_in,
	output logic      [2:0] rd_index_out,
	output logic            busy_out,
	output logic            ctl_sdo_out,
	output logic            ctl_sdo_oe_out,
	cpr_word_if.src         wq
);
	logic [2:0]  sclk_sync_reg;
	logic [1:0]  cs_sync_reg, sdi_sync_reg;
	logic [4:0]  cnt_reg, cnt_next;
	logic [15:0] shift_reg, shift_next;
	logic [7:0]  out_reg, out_next;
	logic        oe_reg, oe_next;
	logic        load_reg, load_next;
	logic        valid_reg, valid_next;
	logic [15:0] word_reg, word_next;
	logic        active, rise, fall;

	assign rd_index_out   = shift_reg[3:1];
	assign busy_out       = oe_reg;
	assign ctl_sdo_out    = out_reg[7];
	assign ctl_sdo_oe_out = oe_reg;
	assign wq.valid       = valid_reg;
	assign wq.data        = word_reg;

	always_comb begin
		active     = !cs_sync_reg[1];
		rise       = sclk_sync_reg[1] && !sclk_sync_reg[2];
		fall       = !sclk_sync_reg[1] && sclk_sync_reg[2];
		cnt_next   = cnt_reg;
		shift_next = shift_reg;
		out_next   = out_reg;
		oe_next    = oe_reg;
		load_next  = 1'b0;
		word_next  = word_reg;
		valid_next = valid_reg && !wq.ready;
		if (!active) begin
			cnt_next = '0;
			oe_next  = 1'b0;
		end else if (rise && cnt_reg != BITS_WORD) begin
			shift_next = {shift_reg[14:0], sdi_sync_reg[1]};
			cnt_next   = cnt_reg + 5'h01;
			load_next  = (cnt_reg == BITS_CMD - 5'h01);
			// Word dropped when the queue has not taken the previous one
			if (cnt_reg == BITS_WORD - 5'h01 && shift_reg[14:11] == CMD_WR[3:0]
					&& !valid_next) begin
				word_next  = {shift_reg[14:0], sdi_sync_reg[1]};
				valid_next = 1'b1;
			end
		end
		if (active && load_reg && shift_reg[7:4] == CMD_RD) begin
			out_next = rd_data_in;
			oe_next  = 1'b1;
		end else if (active && fall && oe_reg && cnt_reg > BITS_CMD + 5'h00
				&& cnt_reg < BITS_WORD) begin
			out_next = {out_reg[6:0], 1'b0};
		end
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cs_sync_reg   <= 2'h3;
			sclk_sync_reg <= 3'h0;
			sdi_sync_reg  <= 2'h0;
			cnt_reg       <= '0;
			shift_reg     <= '0;
			out_reg       <= '0;
			oe_reg        <= 1'b0;
			load_reg      <= 1'b0;
			valid_reg     <= 1'b0;
			word_reg      <= '0;
		end else begin
			cs_sync_reg   <= {cs_sync_reg[0], ctl_cs_n_in};
			sclk_sync_reg <= {sclk_sync_reg[1:0], ctl_sclk_in};
			sdi_sync_reg  <= {sdi_sync_reg[0], ctl_sdi_in};
			cnt_reg       <= cnt_next;
			shift_reg     <= shift_next;
			out_reg       <= out_next;
			oe_reg        <= oe_next;
			load_reg      <= load_next;
			valid_reg     <= valid_next;
			word_reg      <= word_next;
		end
	end
endmodule // cpr_ctl_port

// *** bench/cpr_top_monitor.sv ***
`timescale 1ns/1ps
module cpr_top_monitor
	import cpr_pkg::*;
(
	input wire logic                 mclk_in,
	input wire logic                 sys_rst_in,
	input wire logic                 por_reset_n_in,
	input wire logic                 hold_reset_n_in,
	input wire logic [1:0]           rate_mode_in,
	input wire logic                 i2s_interface_select_in,
	input wire logic                 soft_mute_pin_in,
	input wire cpr_pkg::cpr_fmt_type dac3_format_out,
	input wire cpr_pkg::cpr_fmt_type dac2_format_out,
	input wire cpr_pkg::cpr_fmt_type dac1_format_out,
	input wire cpr_pkg::cpr_fmt_type passthru_input_format_out,
	input wire cpr_pkg::cpr_fmt_type passthru_output_format_out,
	input wire logic                 passthru_frame_delay_out,
	input wire logic [11:0]          mclk_ratio_out,
	input wire logic                 mclk_halve_out,
	input wire logic [3:0]           adc1_source_select_out,
	input wire logic [3:0]           adc2_source_select_out,
	input wire logic                 adc1_reset_out,
	input wire logic                 adc2_reset_out,
	input wire logic                 dac_reset_out,
	input wire logic                 soft_mute_out
);
	logic [2:0] run_cnt;
	logic       settled;

	// Cycles since reset release, so pipelines have flushed
	always_ff @(posedge mclk_in or posedge sys_rst_in)
		if (sys_rst_in)
			run_cnt <= 3'h0;
		else if (run_cnt != 3'h7)
			run_cnt <= run_cnt + 3'h1;
	assign settled = (run_cnt == 3'h7);

	default clocking @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);

	AST_I2S_FORCES_DAC: assert property (
		settled && i2s_interface_select_in && $past(i2s_interface_select_in) |->
		dac3_format_out == FMT_I2S && dac2_format_out == FMT_I2S && dac1_format_out == FMT_I2S)
		else $error("dac format not i2s in i2s mode");
	AST_DAC_CODE_SET: assert property (
		settled && !i2s_interface_select_in && !$past(i2s_interface_select_in) |->
		dac1_format_out inside {FMT_MSB24, FMT_LSB24, FMT_LSB16, FMT_NA})
		else $error("dac format outside its code set");
	AST_RATIO_MODE3_NA: assert property (
		settled && rate_mode_in == 2'b11 && $past(rate_mode_in) == 2'b11 |->
		mclk_ratio_out == RATIO_NA)
		else $error("ratio given for unavailable rate mode");
	AST_HALVE_RATIOS: assert property (
		settled && mclk_halve_out && $past(mclk_halve_out) && $stable(rate_mode_in) |->
		mclk_ratio_out inside {12'h000, 12'h200, 12'h300, 12'h800, 12'hc00})
		else $error("ratio not doubled while halving");
	AST_THROUGH_BOTH: assert property (
		settled |-> (passthru_input_format_out == FMT_THROUGH) ==
		(passthru_output_format_out == FMT_THROUGH))
		else $error("through set on one pass field only");
	AST_FRAME_DELAY: assert property (
		settled && $stable(passthru_input_format_out) && passthru_input_format_out != FMT_NA |->
		passthru_frame_delay_out == (passthru_input_format_out != FMT_THROUGH))
		else $error("frame delay flag wrong");
	AST_SYSRST_HOLDS: assert property (
		(!hold_reset_n_in) [*5] |-> dac_reset_out && adc1_reset_out && adc2_reset_out)
		else $error("converters not held in system reset");
	AST_POR_DEFAULTS: assert property (
		(!por_reset_n_in) [*6] |-> adc1_source_select_out == SRC_PAIR1 &&
		adc2_source_select_out == SRC_PAIR2 && passthru_input_format_out == FMT_THROUGH)
		else $error("defaults not loaded under power-on reset");
	AST_SOURCE_RANGE: assert property (
		adc1_source_select_out inside {4'h1, [4'h3:4'h9]} &&
		adc2_source_select_out inside {[4'h2:4'h9]})
		else $error("source number out of range");
	AST_MUTE_PIN: assert property (
		soft_mute_pin_in [*5] |-> soft_mute_out)
		else $error("mute pin not followed");
endmodule // cpr_top_monitor

bind cpr_top cpr_top_monitor u_mon (.*);

// *** bench/cpr_host_model.sv ***
`timescale 1ns/1ps
module cpr_host_model (
	input  wire logic mclk_in,
	input  wire logic sdo_in,
	input  wire logic sdo_oe_in,
	output logic      cs_n_out,
	output logic      sclk_out,
	output logic      sdi_out
);
	int half = 5;

	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		sdi_out = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask

	// Command byte then data byte, MSB first; reads sampled before each of the 8 data-byte rises
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] wdat, output logic [7:0] rdat);
		logic [15:0] word;
		word = {cmd, wdat & 8'hfe};
		rdat = 8'h00;
		cs_n_out = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			sdi_out = word[i];
			wait_clk(half);
			if (i < 8)
				rdat = {rdat[6:0], sdo_oe_in ? sdo_in : 1'bx};
			sclk_out = 1'b1;
			wait_clk(half);
			sclk_out = 1'b0;
		end
		wait_clk(half);
		cs_n_out = 1'b1;
		// Idle data line shows no stale bit
		sdi_out = ~sdi_out;
		wait_clk(2 * half);
	endtask
endmodule // cpr_host_model

// *** bench/cpr_top_tb.sv ***
`timescale 1ns/1ps
module cpr_top_tb;
	import cpr_pkg::*;
	logic        mclk_in = 1'b0, sys_rst_in = 1'b1, por_reset_n_in = 1'b0, hold_reset_n_in = 1'b0;
	logic        ctl_cs_n_in, ctl_sclk_in, ctl_sdi_in, ctl_sdo_out, ctl_sdo_oe_out, ctl_ready_out;
	logic [1:0]  rate_mode_in = 2'b00;
	logic        i2s_interface_select_in = 1'b0, frame_clock_in = 1'b0, soft_mute_pin_in = 1'b0;
	logic        adc1_data_in = 1'b1, adc2_data_in = 1'b0, serial_pass_in = 1'b1;
	logic        serial_out_one_out, serial_out_two_out, passthru_frame_delay_out, mclk_halve_out;
	cpr_fmt_type dac3_format_out, dac2_format_out, dac1_format_out;
	cpr_fmt_type passthru_input_format_out, passthru_output_format_out;
	logic [11:0] mclk_ratio_out;
	logic [3:0]  adc1_source_select_out, adc2_source_select_out;
	logic        adc1_reset_out, adc2_reset_out, dac_reset_out, soft_mute_out;
	logic [7:0]  d, pt_last;
	logic        mclk_ratio_select;
	int          n_errors = 0, n_tests = 0, cycles = 0;
	integer      seed = 32'h0d811039;

	cpr_top DUT (.mclk_in, .sys_rst_in, .por_reset_n_in, .hold_reset_n_in, .ctl_cs_n_in,
		.ctl_sclk_in, .ctl_sdi_in, .ctl_sdo_out, .ctl_sdo_oe_out, .ctl_ready_out, .rate_mode_in,
		.i2s_interface_select_in, .frame_clock_in, .soft_mute_pin_in, .adc1_data_in, .adc2_data_in,
		.serial_pass_in, .serial_out_one_out, .serial_out_two_out, .dac3_format_out,
		.dac2_format_out, .dac1_format_out, .passthru_input_format_out, .passthru_output_format_out,
		.passthru_frame_delay_out, .mclk_ratio_out, .mclk_halve_out, .adc1_source_select_out,
		.adc2_source_select_out, .adc1_reset_out, .adc2_reset_out, .dac_reset_out, .soft_mute_out);
	cpr_host_model host (.mclk_in, .sdo_in(ctl_sdo_out), .sdo_oe_in(ctl_sdo_oe_out),
		.cs_n_out(ctl_cs_n_in), .sclk_out(ctl_sclk_in), .sdi_out(ctl_sdi_in));

	always #5 mclk_in = ~mclk_in;

	function automatic cpr_fmt_type exp_dac(input logic [1:0] c, input logic i2s);
		if (i2s)
			return FMT_I2S;
		return c == 2'b00 ? FMT_MSB24 : c == 2'b01 ? FMT_LSB24 : c == 2'b11 ? FMT_LSB16 : FMT_NA;
	endfunction

	function automatic cpr_fmt_type exp_pt(input logic [1:0] c, input logic [1:0] o, input logic i2s);
		if (c == 2'b00 || o == 2'b00)
			return FMT_THROUGH;
		if (c == 2'b01)
			return i2s ? FMT_I2S : FMT_MSB24;
		return i2s ? FMT_NA : (c == 2'b10 ? FMT_LSB24 : FMT_LSB16);
	endfunction

	function automatic logic [11:0] exp_ratio(input logic [1:0] m, input logic k, input logic h);
		logic [11:0] r;
		r = m == 2'b00 ? (k ? 12'h180 : 12'h100) : m == 2'b01 ? (k ? 12'h600 : 12'h400)
			: (m == 2'b10 && !k && !h) ? 12'h100 : 12'h000;
		return h ? {r[10:0], 1'b0} : r;
	endfunction

	task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic bit_check(input string what, input logic exp, input logic got);
		check(what, {11'h000, exp}, {11'h000, got});
	endtask

	task automatic wr(input logic [7:0] off, input logic [7:0] dat);
		logic [7:0] r;
		host.xfer(off, dat, r);
		host.wait_clk(8);
	endtask

	// Read command sent with a random low bit, which the device ignores
	task automatic rd(input logic [7:0] off, input logic [7:0] exp);
		logic [7:0] r;
		host.xfer(off | 8'h10 | {7'h00, 1'($random(seed))}, 8'h00, r);
		check("readback", {4'h0, exp}, {4'h0, r});
	endtask

	task automatic frame_to(input logic v);
		frame_clock_in = v;
		{adc1_data_in, adc2_data_in, serial_pass_in} = 3'($random(seed));
		host.wait_clk(8);
	endtask

	function automatic logic exp_out(input logic [2:0] r, input logic own, input logic other);
		return !r[2] && (r[0] ? serial_pass_in : r[1] ? other : own);
	endfunction

	// Routing in force per output: force low, swap, pass-in
	task automatic outs(input logic [5:0] r, input logic ps1);
		logic a1;
		a1 = adc1_data_in && !ps1;
		bit_check("serial out one", exp_out(r[5:3], a1, adc2_data_in), serial_out_one_out);
		bit_check("serial out two", exp_out(r[2:0], adc2_data_in, a1), serial_out_two_out);
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 60000) begin
			n_errors++;
			complete_run();
		end
	end

	initial begin
		host.wait_clk(12);
		sys_rst_in = 1'b0;
		host.wait_clk(10);
		bit_check("adc1 reset", 1'b1, adc1_reset_out);
		for (int i = 1; i < 8; i++)
			rd({4'h2, 3'(i), 1'b0}, 8'h00);
		por_reset_n_in = 1'b1;
		host.wait_clk(6);
		bit_check("ready", 1'b1, ctl_ready_out);
		for (int c = 0; c < 4; c++) begin
			rate_mode_in = 2'(c);
			mclk_ratio_select = 1'($random(seed));
			d = {2'(c), 2'(c), 2'(c), mclk_ratio_select, 1'b0};
			wr(OFF_FMT, d);
			rd(OFF_FMT, d);
			check("dac3", exp_dac(2'(c), 1'b0), dac3_format_out);
			check("dac1", exp_dac(2'(c), 1'b0), dac1_format_out);
			check("ratio", exp_ratio(rate_mode_in, mclk_ratio_select, 1'b0), mclk_ratio_out);
		end
		rate_mode_in = 2'b01;
		wr(OFF_FMT, {6'h00, mclk_ratio_select, 1'b0});
		for (int k = 0; k < 16; k++) begin
			i2s_interface_select_in = 1'($random(seed));
			d = {4'(k), 2'b00, 1'($random(seed)), 1'b0};
			wr(OFF_PT, d);
			check("dac2", exp_dac(2'b00, i2s_interface_select_in), dac2_format_out);
			check("pt in", exp_pt(d[7:6], d[5:4], i2s_interface_select_in),
				passthru_input_format_out);
			check("pt out", exp_pt(d[5:4], d[7:6], i2s_interface_select_in),
				passthru_output_format_out);
			bit_check("delay", d[7:6] != 2'b00 && d[5:4] != 2'b00, passthru_frame_delay_out);
			check("ratio", exp_ratio(2'b01, mclk_ratio_select, d[1]), mclk_ratio_out);
		end
		pt_last = d;
		for (int c = 0; c < 8; c++) begin
			wr(OFF_ADC1, {3'(c), 5'h00});
			wr(OFF_ADC2, {~3'(c), 5'h00});
			check("adc1 src", c == 0 ? 4'h1 : 4'(c + 2), adc1_source_select_out);
			check("adc2 src", c == 7 ? 4'h2 : 4'(9 - c), adc2_source_select_out);
		end
		i2s_interface_select_in = 1'b0;
		hold_reset_n_in = 1'b1;
		host.wait_clk(8);
		bit_check("dac reset", 1'b0, dac_reset_out);
		frame_to(1'b1);
		frame_to(1'b0);
		outs(6'h00, 1'b0);
		wr(OFF_PT, 8'h0c);
		outs(6'h00, 1'b0);
		frame_to(1'b1);
		outs(6'h24, 1'b0);
		frame_to(1'b0);
		rd(OFF_PT, (pt_last & 8'hf2) | 8'h0c);
		wr(OFF_PT, 8'h00);
		wr(OFF_ADC1, 8'h10);
		wr(OFF_ADC2, 8'h10);
		frame_to(1'b1);
		outs(6'h12, 1'b0);
		wr(OFF_ADC1, 8'h08);
		frame_to(1'b0);
		frame_to(1'b1);
		outs(6'h0a, 1'b0);
		frame_to(1'b0);
		i2s_interface_select_in = 1'b1;
		wr(OFF_ADC1, 8'h00);
		frame_to(1'b1);
		outs(6'h0a, 1'b0);
		frame_to(1'b0);
		outs(6'h02, 1'b0);
		i2s_interface_select_in = 1'b0;
		wr(OFF_ADC1, 8'h04);
		bit_check("adc1 reset", 1'b1, adc1_reset_out);
		frame_to(1'b1);
		outs(6'h02, 1'b1);
		frame_to(1'b0);
		wr(OFF_ADC1, 8'h00);
		rd(OFF_ADC1, 8'h04);
		host.half = 9;
		wr(OFF_DAC, 8'h80);
		bit_check("mute", 1'b1, soft_mute_out);
		rd(OFF_DAC, 8'h80);
		wr(OFF_DAC, 8'h00);
		soft_mute_pin_in = 1'b1;
		host.wait_clk(6);
		bit_check("mute", 1'b1, soft_mute_out);
		soft_mute_pin_in = 1'b0;
		host.wait_clk(6);
		bit_check("mute", 1'b0, soft_mute_out);
		complete_run();
	end
endmodule // cpr_top_tb
